/* logic/oag_core.sv */
// operand address generator: effective addresses and immediates
`default_nettype none
`include "oag_regs.svh"
module oag_core (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic req_valid_i,
  input wire oag_pkg::oag_mode_e mode_i,
  input wire oag_pkg::oag_size_e size_i,
  input wire oag_pkg::oag_imm_e imm_kind_i,
  input wire logic [11:0] disp_i,
  input wire logic [7:0] imm_i,
  input wire logic [31:0] selected_general_register_i,
  input wire logic [31:0] index_register_zero_i,
  input wire logic [31:0] global_base_register_i,
  input wire logic [31:0] pc_i,
  output logic [31:0] ea_o,
  output logic mem_access_o,
  output logic [31:0] operand_o,
  output logic operand_is_reg_o,
  output logic [31:0] reg_wb_data_o,
  output logic reg_wb_en_o,
  output logic [31:0] target_o,
  output logic target_valid_o,
  output logic [31:0] imm_ext_o,
  output logic size_err_o
);
  ////////////////////////////////////////////////////////////////////////////
  // displacement extension and scaling
  oag_scale_if sc ();
  logic [31:0] rn, r0, global_base_register, pc;
  logic [31:0] disp4_zx, disp8_zx, disp8_sx, disp12_sx, disp_sel;
  assign rn = selected_general_register_i;
  assign r0 = index_register_zero_i;
  assign global_base_register = global_base_register_i;
  assign pc = pc_i;
  assign disp4_zx = {28'h0, disp_i[3:0]};
  assign disp8_zx = {24'h0, disp_i[7:0]};
  assign disp8_sx = {{24{disp_i[7]}}, disp_i[7:0]};
  assign disp12_sx = {{20{disp_i[11]}}, disp_i[11:0]};
  // pick which displacement the scaler sees
  assign disp_sel = (mode_i == oag_pkg::OAG_AM_REG_DISP) ? disp4_zx
                  : (mode_i == oag_pkg::OAG_AM_GBR_DISP) ? disp8_zx
                  : (mode_i == oag_pkg::OAG_AM_PC_DISP) ? disp8_zx
                  : 32'h0;
  assign sc.disp = disp_sel;
  assign sc.size = size_i;
  oag_scaler u_scaler (
    .sc(sc.unit)
  );
  ////////////////////////////////////////////////////////////////////////////
  // address arithmetic, all modulo 2^32
  logic [31:0] rn_inc, rn_dec, pc_base, pc_disp_ea, br_short, br_long;
  logic [31:0] rn_disp_ea, gbr_disp_ea;
  assign rn_inc = rn + sc.step;
  assign rn_dec = rn - sc.step;
  assign rn_disp_ea = rn + sc.scaled;
  assign gbr_disp_ea = global_base_register + sc.scaled;
  // longword loads mask pc to a longword boundary
  assign pc_base = (size_i == oag_pkg::OAG_SZ_LONG) ?
                   (pc & `OAG_PC_LW_MASK) : pc;
  assign pc_disp_ea = pc_base + sc.scaled;
  // branch displacements count 16-bit instructions
  assign br_short = pc + {disp8_sx[30:0], 1'h0};
  assign br_long = pc + {disp12_sx[30:0], 1'h0};
  ////////////////////////////////////////////////////////////////////////////
  // mode decode into next values
  logic [31:0] ea_nxt, operand_nxt, wb_nxt, target_nxt, imm_nxt;
  logic mem_nxt, opreg_nxt, wb_en_nxt, tgt_nxt, err_nxt;
  always_comb begin
    ea_nxt = 32'h0;
    operand_nxt = 32'h0;
    wb_nxt = 32'h0;
    target_nxt = 32'h0;
    mem_nxt = 1'b0;
    opreg_nxt = 1'b0;
    wb_en_nxt = 1'b0;
    tgt_nxt = 1'b0;
    err_nxt = 1'b0;
    case (mode_i)
      oag_pkg::OAG_AM_DIRECT: begin
        operand_nxt = rn;
        opreg_nxt = 1'b1;
      end
      oag_pkg::OAG_AM_INDIRECT: begin
        ea_nxt = rn;
        mem_nxt = 1'b1;
      end
      oag_pkg::OAG_AM_POSTINC: begin
        ea_nxt = rn;
        mem_nxt = 1'b1;
        wb_nxt = rn_inc;
        wb_en_nxt = 1'b1;
      end
      oag_pkg::OAG_AM_PREDEC: begin
        ea_nxt = rn_dec;
        mem_nxt = 1'b1;
        wb_nxt = rn_dec;
        wb_en_nxt = 1'b1;
      end
      oag_pkg::OAG_AM_REG_DISP: begin
        ea_nxt = rn_disp_ea;
        mem_nxt = 1'b1;
      end
      oag_pkg::OAG_AM_REG_INDEX: begin
        ea_nxt = rn + r0;
        mem_nxt = 1'b1;
      end
      oag_pkg::OAG_AM_GBR_DISP: begin
        ea_nxt = gbr_disp_ea;
        mem_nxt = 1'b1;
      end
      oag_pkg::OAG_AM_GBR_INDEX: begin
        ea_nxt = global_base_register + r0;
        mem_nxt = 1'b1;
      end
      oag_pkg::OAG_AM_PC_DISP: begin
        // byte size (and the unused code, read as byte) is refused here
        if (size_i != oag_pkg::OAG_SZ_WORD &&
            size_i != oag_pkg::OAG_SZ_LONG) begin
          err_nxt = 1'b1;
        end else begin
          ea_nxt = pc_disp_ea;
          mem_nxt = 1'b1;
        end
      end
      oag_pkg::OAG_AM_PC_SHORT: begin
        target_nxt = br_short;
        tgt_nxt = 1'b1;
      end
      oag_pkg::OAG_AM_PC_LONG: begin
        target_nxt = br_long;
        tgt_nxt = 1'b1;
      end
      oag_pkg::OAG_AM_PC_REG: begin
        target_nxt = pc + rn;
        tgt_nxt = 1'b1;
      end
      default: begin
        err_nxt = 1'b1;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  // immediate extension
  assign imm_nxt = (imm_kind_i == oag_pkg::OAG_IMM_SIGN)
                 ? {{24{imm_i[7]}}, imm_i}
                 : (imm_kind_i == oag_pkg::OAG_IMM_TRAP)
                 ? {22'h0, imm_i, 2'h0}
                 : {24'h0, imm_i};
  ////////////////////////////////////////////////////////////////////////////
  // output registers, one cycle after a valid request
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ea_o <= 32'h0;
      operand_o <= 32'h0;
      reg_wb_data_o <= 32'h0;
      target_o <= 32'h0;
      imm_ext_o <= 32'h0;
    end else if (req_valid_i) begin
      ea_o <= ea_nxt;
      operand_o <= operand_nxt;
      reg_wb_data_o <= wb_nxt;
      target_o <= target_nxt;
      imm_ext_o <= imm_nxt;
    end
  end
  // strobes last exactly one cycle per request
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      mem_access_o <= 1'b0;
      operand_is_reg_o <= 1'b0;
      reg_wb_en_o <= 1'b0;
      target_valid_o <= 1'b0;
      size_err_o <= 1'b0;
    end else begin
      mem_access_o <= req_valid_i & mem_nxt;
      operand_is_reg_o <= req_valid_i & opreg_nxt;
      reg_wb_en_o <= req_valid_i & wb_en_nxt;
      target_valid_o <= req_valid_i & tgt_nxt;
      size_err_o <= req_valid_i & err_nxt;
    end
  end
endmodule // oag_core
`default_nettype wire

/* common/oag_regs.svh */
// constants for the operand address generator
`ifndef OAG_REGS_SVH
`define OAG_REGS_SVH
`define OAG_XW 32
`define OAG_PC_LW_MASK 32'hffff_fffc
`define OAG_STEP_BYTE 32'h0000_0001
`define OAG_STEP_WORD 32'h0000_0002
`define OAG_STEP_LONG 32'h0000_0004
`define OAG_TRAP_SHIFT 2
`endif

/* common/oag_pkg.sv */
// types for the operand address generator
`default_nettype none
package oag_pkg;
  typedef enum logic [1:0] {
    OAG_SZ_BYTE = 2'h0,
    OAG_SZ_WORD = 2'h1,
    OAG_SZ_LONG = 2'h2
  } oag_size_e;
  typedef enum logic [3:0] {
    OAG_AM_DIRECT = 4'h0,
    OAG_AM_INDIRECT = 4'h1,
    OAG_AM_POSTINC = 4'h2,
    OAG_AM_PREDEC = 4'h3,
    OAG_AM_REG_DISP = 4'h4,
    OAG_AM_REG_INDEX = 4'h5,
    OAG_AM_GBR_DISP = 4'h6,
    OAG_AM_GBR_INDEX = 4'h7,
    OAG_AM_PC_DISP = 4'h8,
    OAG_AM_PC_SHORT = 4'h9,
    OAG_AM_PC_LONG = 4'ha,
    OAG_AM_PC_REG = 4'hb
  } oag_mode_e;
  typedef enum logic [1:0] {
    OAG_IMM_ZERO = 2'h0,
    OAG_IMM_SIGN = 2'h1,
    OAG_IMM_TRAP = 2'h2
  } oag_imm_e;
endpackage : oag_pkg
`default_nettype wire

/* common/oag_scale_if.sv */
// carries a displacement and size into the scaler and the result out
`default_nettype none
interface oag_scale_if;
  logic [31:0] disp;
  oag_pkg::oag_size_e size;
  logic [31:0] scaled;
  logic [31:0] step;
  modport core (output disp, output size, input scaled, input step);
  modport unit (input disp, input size, output scaled, output step);
endinterface : oag_scale_if
`default_nettype wire

/* logic/oag_scaler.sv */
// scales a displacement by operand size and gives the size step
`default_nettype none
`include "oag_regs.svh"
module oag_scaler (
  oag_scale_if.unit sc
);
  // byte keeps the value, word doubles, longword quadruples
  assign sc.scaled = (sc.size == oag_pkg::OAG_SZ_LONG) ? {sc.disp[29:0], 2'h0}
                   : (sc.size == oag_pkg::OAG_SZ_WORD) ? {sc.disp[30:0], 1'h0}
                   : sc.disp;
  // step for post-increment and pre-decrement
  assign sc.step = (sc.size == oag_pkg::OAG_SZ_LONG) ? `OAG_STEP_LONG
                 : (sc.size == oag_pkg::OAG_SZ_WORD) ? `OAG_STEP_WORD
                 : `OAG_STEP_BYTE;
endmodule // oag_scaler
`default_nettype wire

/* sim/oag_regfile_model.sv */
// register file stand-in holding the selected general register
`default_nettype none
module oag_regfile_model (
  input wire logic clk_i,
  input wire logic load_i,
  input wire logic [31:0] load_val_i,
  input wire logic wb_en_i,
  input wire logic [31:0] wb_data_i,
  output logic [31:0] reg_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // bench load wins, else commit the write-back after the access
  always @(posedge clk_i) begin
    if (load_i) reg_o <= load_val_i;
    else if (wb_en_i) reg_o <= wb_data_i;
  end
endmodule // oag_regfile_model
`default_nettype wire

/* sim/oag_core_assertions.sv */
// port checks for the operand address generator
`default_nettype none
module oag_core_chk (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic req_valid_i,
  input wire oag_pkg::oag_mode_e mode_i,
  input wire oag_pkg::oag_size_e size_i,
  input wire oag_pkg::oag_imm_e imm_kind_i,
  input wire logic [7:0] imm_i,
  input wire logic [31:0] selected_general_register_i,
  input wire logic [31:0] index_register_zero_i,
  input wire logic [31:0] global_base_register_i,
  input wire logic [31:0] ea_o,
  input wire logic mem_access_o,
  input wire logic [31:0] reg_wb_data_o,
  input wire logic reg_wb_en_o,
  input wire logic operand_is_reg_o,
  input wire logic [31:0] imm_ext_o,
  input wire logic size_err_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // taken request and short names for the source registers
  wire logic tk = reset_n_i && req_valid_i;
  wire logic [31:0] rn = selected_general_register_i;
  wire logic [31:0] r0 = index_register_zero_i;
  direct_operand_a:
    assert property (tk && mode_i == 4'h0 |=> operand_is_reg_o
      && !mem_access_o) else $error("direct mode");
  indirect_addr_a:
    assert property (tk && mode_i == 4'h1 |=> mem_access_o && !reg_wb_en_o
      && ea_o == $past(rn)) else $error("indirect mode");
  postinc_step_a:
    assert property (tk && mode_i == 4'h2 && size_i == 2'h2 |=> reg_wb_en_o
      && reg_wb_data_o == ea_o + 32'h4) else $error("post-increment");
  predec_step_a:
    assert property (tk && mode_i == 4'h3 && size_i == 2'h1 |=>
      ea_o == $past(rn) - 32'h2 && reg_wb_data_o == ea_o) else $error("pre-dec");
  reg_index_a:
    assert property (tk && mode_i == 4'h5 |=>
      ea_o == $past(rn) + $past(r0)) else $error("indexed register");
  base_index_a:
    assert property (tk && mode_i == 4'h7 |=> ea_o ==
      $past(global_base_register_i) + $past(r0)) else $error("indexed base");
  pc_byte_a:
    assert property (tk && mode_i == 4'h8 && size_i == 2'h0 |=> size_err_o
      && !mem_access_o && ea_o == 32'h0) else $error("pc byte refused");
  trap_scale_a:
    assert property (tk && imm_kind_i == 2'h2 |=>
      imm_ext_o == {22'h0, $past(imm_i), 2'h0}) else $error("trap offset");
endmodule // oag_core_chk
bind oag_core oag_core_chk u_chk (.*);
`default_nettype wire

/* sim/oag_core_tb_top.sv */
// random self-checking bench for the operand address generator
`default_nettype none
module oag_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0, reset_n_i = 1'b0, req_valid_i = 1'b0, ld = 1'b0;
  oag_pkg::oag_mode_e mode_i = oag_pkg::OAG_AM_DIRECT;
  oag_pkg::oag_size_e size_i = oag_pkg::OAG_SZ_BYTE;
  oag_pkg::oag_imm_e imm_kind_i = oag_pkg::OAG_IMM_ZERO;
  logic [11:0] disp_i = 12'h0;
  logic [7:0] imm_i = 8'h0;
  logic [31:0] index_register_zero_i = 32'h0, global_base_register_i = 32'h0;
  logic [31:0] pc_i = 32'h0, ld_v = 32'h0, selected_general_register_i;
  logic [31:0] ea_o, operand_o, reg_wb_data_o, target_o, imm_ext_o;
  logic mem_access_o, operand_is_reg_o, reg_wb_en_o, target_valid_o, size_err_o;
  logic [31:0] rn, sc, d, ea, wb, tg, im;
  logic me, we, tv, er, ir;
  int m, miscompares = 0, checked = 0;
  // 50 MHz clock
  always #10 sys_clk_i = ~sys_clk_i;
  oag_core DUT (.*);
  oag_regfile_model u_rf (.clk_i(sys_clk_i), .load_i(ld), .load_val_i(ld_v),
    .wb_en_i(reg_wb_en_o), .wb_data_i(reg_wb_data_o),
    .reg_o(selected_general_register_i));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // cut a hang short
  initial begin
    #60000;
    miscompares++;
    tally_and_finish();
  end
  // load a register, issue one request, compare with the model
  initial begin
    void'($urandom(32'ha343));
    repeat (6) @(posedge sys_clk_i);
    chk("reset ea", ea_o, 32'h0);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 256; i++) begin
      @(posedge sys_clk_i);
      ld <= 1'b1;
      ld_v <= $urandom;
      @(posedge sys_clk_i);
      ld <= 1'b0;
      m = i % 16;
      mode_i <= oag_pkg::oag_mode_e'(4'(m));
      size_i <= oag_pkg::oag_size_e'(2'(i / 16));
      imm_kind_i <= oag_pkg::oag_imm_e'(2'(i % 3));
      disp_i <= 12'($urandom);
      imm_i <= 8'($urandom);
      index_register_zero_i <= $urandom;
      global_base_register_i <= $urandom;
      pc_i <= $urandom;
      req_valid_i <= 1'b1;
      @(posedge sys_clk_i);
      req_valid_i <= 1'b0;
      #1;
      rn = ld_v;
      sc = size_i == 2'h1 ? 32'h2 : size_i == 2'h2 ? 32'h4 : 32'h1;
      d = {20'h0, disp_i};
      er = m > 11 || (m == 8 && sc == 32'h1);
      me = m inside {[1:8]} && !er;
      we = m inside {[2:3]};
      tv = m inside {[9:11]};
      ir = m == 0;
      case (m)
        1, 2: ea = rn;
        3: ea = rn - sc;
        4: ea = rn + d[3:0] * sc;
        5: ea = rn + index_register_zero_i;
        6: ea = global_base_register_i + d[7:0] * sc;
        7: ea = global_base_register_i + index_register_zero_i;
        8: ea = er ? 32'h0 : d[7:0] * sc
          + (pc_i & (sc == 32'h4 ? 32'hffff_fffc : 32'hffff_ffff));
        default: ea = 32'h0;
      endcase
      wb = m == 2 ? rn + sc : m == 3 ? ea : rn;
      tg = pc_i + (m == 9 ? {{23{d[7]}}, d[7:0], 1'b0}
        : m == 10 ? {{19{d[11]}}, d[11:0], 1'b0} : rn);
      im = imm_kind_i == 2'h1 ? {{24{imm_i[7]}}, imm_i}
        : {24'h0, imm_i} << (imm_kind_i == 2'h2 ? 2 : 0);
      chk("pulses", {27'h0, mem_access_o, reg_wb_en_o, size_err_o,
        target_valid_o, operand_is_reg_o}, {27'h0, me, we, er, tv, ir});
      if (me || er) chk("ea", ea_o, ea);
      if (ir) chk("operand", operand_o, rn);
      if (tv) chk("target", target_o, tg);
      chk("imm_ext", imm_ext_o, im);
      @(posedge sys_clk_i);
      #1;
      chk("register", selected_general_register_i, wb);
    end
    tally_and_finish();
  end
endmodule // oag_core_tb_top
`default_nettype wire
